// [design/pcs_top.sv]
// Process PI controller with source selection and display scaling
`timescale 1ns/1ps
module pcs_top import pcs_pkg::*; #(
  parameter int TICK_CYC = PCS_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Measurements and standby restart
  input wire pcs_meas_t meas,
  input wire logic standby_wake,
  // Results
  output logic [9:0] freq_ref,
  output logic [23:0] display_value
);
  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  pcs_pi_cfg_t cfg_r, cfg_nxt;
  pcs_dsp_cfg_t dsp_r, dsp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    dsp_nxt = dsp_r;
    if (wr) begin
      // Writes beyond a setting's range leave it untouched
      case (addr)
        PCS_KP_OFF: if (wdata <= PCS_KP_MAX) cfg_nxt.kp = wdata[8:0];
        PCS_TI_OFF: if (wdata <= PCS_TI_MAX) cfg_nxt.ti = wdata[8:0];
        PCS_MODE_OFF: if (wdata <= PCS_MODE_MAX) cfg_nxt.mode = wdata[1:0];
        PCS_SPSRC_OFF: if (wdata <= PCS_SPSRC_MAX) cfg_nxt.sp_src = wdata[1:0];
        PCS_SPDIG_OFF: if (wdata <= PCS_PCT_MAX) cfg_nxt.sp_dig = wdata[9:0];
        PCS_FBSRC_OFF: if (wdata <= PCS_FBSRC_MAX) cfg_nxt.fb_src = wdata[2:0];
        PCS_DFACT_OFF: if (wdata <= PCS_DFACT_MAX) dsp_nxt.factor = wdata[13:0];
        PCS_DSRC_OFF: if (wdata <= PCS_DSRC_MAX) dsp_nxt.src = wdata[1:0];
        PCS_UNITS_OFF: dsp_nxt.speed_units = (wdata != 32'h0000_0000);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Setpoint and feedback selection
  // ----------------------------------------------------------------
  logic [9:0] sp_sel, fb_sel, fb_bus;
  logic [15:0] dc_pct;

  always_comb begin
    sp_sel = cfg_r.sp_dig;
    case (cfg_r.sp_src)
      2'd0: sp_sel = cfg_r.sp_dig;
      2'd1: sp_sel = meas.ain1;
      2'd2: begin
        if (meas.fieldbus_process_word_two > 16'(PCS_PCT_MAX)) begin
          sp_sel = PCS_PCT_FULL;
        end else begin
          sp_sel = meas.fieldbus_process_word_two[9:0];
        end
      end
      default: sp_sel = cfg_r.sp_dig;
    endcase
  end

  // One volt per 0.1 %: 1000 V is full scale
  always_comb begin
    dc_pct = meas.dc_volts;
    if (dc_pct > 16'(PCS_PCT_MAX)) begin
      fb_bus = PCS_PCT_FULL;
    end else begin
      fb_bus = dc_pct[9:0];
    end
  end

  always_comb begin
    fb_sel = meas.ain2;
    case (cfg_r.fb_src)
      3'd0: fb_sel = meas.ain2;
      3'd1: fb_sel = meas.ain1;
      3'd2: fb_sel = meas.cur_pct;
      3'd3: fb_sel = fb_bus;
      3'd4: fb_sel = (meas.ain1 > meas.ain2) ? meas.ain1 - meas.ain2 : 10'h000;
      3'd5: fb_sel = (meas.ain1 > meas.ain2) ? meas.ain1 : meas.ain2;
      default: fb_sel = meas.ain2;
    endcase
  end

  // ----------------------------------------------------------------
  // PI controller
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic signed [31:0] acc_r, acc_nxt;
  logic [9:0] out_r, out_nxt;
  logic tick;
  logic signed [11:0] err;
  logic signed [31:0] pterm, incr, sum, acc_try;
  localparam logic signed [31:0] ACC_FULL = 32'(PCS_PCT_MAX) <<< PCS_ACC_SHIFT;
  // Signed, so a negative sum never compares as a huge unsigned value
  localparam logic signed [31:0] OUT_FULL = 32'(PCS_PCT_MAX);

  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  always_comb begin
    tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    // Direct acts on setpoint minus feedback, inverse on the reverse
    if (cfg_r.mode[0]) begin
      err = $signed({2'b00, fb_sel}) - $signed({2'b00, sp_sel});
    end else begin
      err = $signed({2'b00, sp_sel}) - $signed({2'b00, fb_sel});
    end
    pterm = ($signed({23'h0, cfg_r.kp}) * 32'(err)) / 10;
    // Integral time of zero disables the integral path
    if (cfg_r.ti == 9'h000) begin
      incr = 32'sh0000_0000;
    end else begin
      incr = ($signed({23'h0, cfg_r.kp}) * 32'(err) * 1024)
             / ($signed({23'h0, cfg_r.ti}) * PCS_TI_DIV);
    end
    sum = pterm + (acc_r >>> PCS_ACC_SHIFT);
    acc_try = acc_r + incr;
    acc_nxt = acc_r;
    out_nxt = out_r;
    if (standby_wake && cfg_r.mode[1]) begin
      // Restart from standby lands at full output
      acc_nxt = ACC_FULL;
      out_nxt = PCS_PCT_FULL;
    end else if (tick) begin
      // Hold the integral while it would push further into a saturated limit
      if (!((sum >= OUT_FULL && incr > 0) || (sum <= 0 && incr < 0))) begin
        if (acc_try > ACC_FULL) begin
          acc_nxt = ACC_FULL;
        end else if (acc_try < 0) begin
          acc_nxt = 32'sh0000_0000;
        end else begin
          acc_nxt = acc_try;
        end
      end
      if (sum >= OUT_FULL) begin
        out_nxt = PCS_PCT_FULL;
      end else if (sum <= 0) begin
        out_nxt = 10'h000;
      end else begin
        out_nxt = sum[9:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Display scaling
  // ----------------------------------------------------------------
  logic [15:0] dsp_src_val;
  logic [29:0] dsp_prod;
  logic [23:0] disp_r, disp_nxt;

  always_comb begin
    dsp_src_val = meas.out_freq;
    case (dsp_r.src)
      2'd0: dsp_src_val = dsp_r.speed_units ? meas.motor_rpm : meas.out_freq;
      2'd1: dsp_src_val = meas.cur_amps;
      2'd2: dsp_src_val = {6'h00, meas.ain2};
      2'd3: dsp_src_val = {6'h00, fb_sel};
      default: dsp_src_val = meas.out_freq;
    endcase
    dsp_prod = 30'(dsp_src_val) * 30'(dsp_r.factor);
    disp_nxt = 24'(dsp_prod / 30'(PCS_FACT_DIV));
  end

  // ----------------------------------------------------------------
  // Read port: data in the cycle after the strobe, unmapped reads zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      case (addr)
        PCS_KP_OFF: rdata_nxt = {23'h0, cfg_r.kp};
        PCS_TI_OFF: rdata_nxt = {23'h0, cfg_r.ti};
        PCS_MODE_OFF: rdata_nxt = {30'h0, cfg_r.mode};
        PCS_SPSRC_OFF: rdata_nxt = {30'h0, cfg_r.sp_src};
        PCS_SPDIG_OFF: rdata_nxt = {22'h0, cfg_r.sp_dig};
        PCS_FBSRC_OFF: rdata_nxt = {29'h0, cfg_r.fb_src};
        PCS_DFACT_OFF: rdata_nxt = {18'h0, dsp_r.factor};
        PCS_DSRC_OFF: rdata_nxt = {30'h0, dsp_r.src};
        PCS_UNITS_OFF: rdata_nxt = {31'h0, dsp_r.speed_units};
        PCS_OUT_OFF: rdata_nxt = {22'h0, out_r};
        PCS_FB_OFF: rdata_nxt = {22'h0, fb_sel};
        PCS_DISP_OFF: rdata_nxt = {8'h00, disp_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= '{kp: PCS_KP_RST, ti: PCS_TI_RST, mode: 2'd0, sp_src: 2'd0,
                 sp_dig: PCS_SPDIG_RST, fb_src: 3'd0};
      dsp_r <= '{factor: PCS_DFACT_RST, src: 2'd0, speed_units: 1'b0};
      tick_cnt_r <= 32'h0000_0000;
      acc_r <= 32'sh0000_0000;
      out_r <= 10'h000;
      disp_r <= 24'h00_0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      dsp_r <= dsp_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      acc_r <= acc_nxt;
      out_r <= out_nxt;
      disp_r <= disp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign freq_ref = out_r;
  assign display_value = disp_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Settings port
  kp_reject_a: assert property (
    wr && addr == PCS_KP_OFF && wdata > PCS_KP_MAX |=> cfg_r.kp == $past(cfg_r.kp))
    else $error("out of range gain write was taken");
  kp_accept_a: assert property (
    wr && addr == PCS_KP_OFF && wdata <= PCS_KP_MAX |=> cfg_r.kp == $past(wdata[8:0]))
    else $error("in range gain write was lost");
  ti_reject_a: assert property (
    wr && addr == PCS_TI_OFF && wdata > PCS_TI_MAX |=> $stable(cfg_r.ti))
    else $error("out of range integral time write was taken");
  ti_accept_a: assert property (
    wr && addr == PCS_TI_OFF && wdata <= PCS_TI_MAX |=> cfg_r.ti == $past(wdata[8:0]))
    else $error("in range integral time write was lost");
  read_late_a: assert property (
    rd && addr == PCS_KP_OFF && !$past(wr) |=> rdata == {23'h0, $past(cfg_r.kp)})
    else $error("gain read back wrong");

  // Source selection
  sp_stored_a: assert property (
    cfg_r.sp_src == 2'd0 |-> sp_sel == cfg_r.sp_dig)
    else $error("stored setpoint not selected");
  sp_analog_a: assert property (
    cfg_r.sp_src == 2'd1 |-> sp_sel == meas.ain1)
    else $error("analog setpoint not selected");
  sp_bus_a: assert property (
    cfg_r.sp_src == 2'd2 && meas.fieldbus_process_word_two <= 16'(PCS_PCT_MAX)
    |-> sp_sel == meas.fieldbus_process_word_two[9:0])
    else $error("fieldbus setpoint not selected");
  fb_current_a: assert property (
    cfg_r.fb_src == 3'd2 |-> fb_sel == meas.cur_pct)
    else $error("current feedback not selected");
  dc_clamp_a: assert property (
    cfg_r.fb_src == 3'd3 && meas.dc_volts > 16'(PCS_PCT_MAX) |-> fb_sel == PCS_PCT_FULL)
    else $error("bus voltage feedback not clamped");
  dc_pass_a: assert property (
    cfg_r.fb_src == 3'd3 && meas.dc_volts <= 16'(PCS_PCT_MAX)
    |-> fb_sel == meas.dc_volts[9:0])
    else $error("bus voltage feedback wrong");
  fb_diff_a: assert property (
    cfg_r.fb_src == 3'd4
    |-> fb_sel == ((meas.ain1 > meas.ain2) ? meas.ain1 - meas.ain2 : 10'h000))
    else $error("difference feedback wrong");
  fb_max_a: assert property (
    cfg_r.fb_src == 3'd5 |-> fb_sel >= meas.ain1 && fb_sel >= meas.ain2
    && (fb_sel == meas.ain1 || fb_sel == meas.ain2))
    else $error("largest input feedback wrong");

  // Controller
  direct_sign_a: assert property (
    !cfg_r.mode[0] && fb_sel < sp_sel |-> err > 0)
    else $error("direct action error has wrong sign");
  inverse_sign_a: assert property (
    cfg_r.mode[0] && fb_sel < sp_sel |-> err < 0)
    else $error("inverse action error has wrong sign");
  out_range_a: assert property (
    out_r <= PCS_PCT_FULL)
    else $error("controller output above full scale");
  acc_hold_a: assert property (
    tick && !(standby_wake && cfg_r.mode[1])
    && ((sum >= OUT_FULL && incr > 0) || (sum <= 0 && incr < 0)) |=> $stable(acc_r))
    else $error("integral moved while output saturated");
  wake_full_a: assert property (
    standby_wake && cfg_r.mode[1] |=> freq_ref == PCS_PCT_FULL && acc_r == ACC_FULL)
    else $error("standby restart did not force full output");
  wake_ignore_a: assert property (
    standby_wake && !cfg_r.mode[1] && !tick |=> $stable(freq_ref))
    else $error("standby restart acted in a plain mode");

  // Display
  disp_fb_a: assert property (
    dsp_r.src == 2'd3 && $stable(dsp_r)
    |=> display_value == 24'((30'($past(fb_sel)) * 30'($past(dsp_r.factor)))
                             / 30'(PCS_FACT_DIV)))
    else $error("feedback display scaling wrong");
  disp_zero_a: assert property (
    dsp_r.factor == 14'h0000 |=> display_value == 24'h00_0000)
    else $error("zero factor display not zero");

  wake_c: cover property (standby_wake && cfg_r.mode[1]);
  sat_c: cover property (tick && sum >= OUT_FULL);
  disp_c: cover property (dsp_r.src == 2'd3 && dsp_r.factor != 14'h0000);
  fb_diff_c: cover property (cfg_r.fb_src == 3'd4 && meas.ain1 > meas.ain2);
  inverse_c: cover property (tick && cfg_r.mode[0] && out_r != 10'h000);
endmodule

// [include/pcs_pkg.sv]
// Package of constants and carrier types for the process PI and display scaling block
package pcs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCS_KP_OFF = 8'h00;
  localparam logic [7:0] PCS_TI_OFF = 8'h04;
  localparam logic [7:0] PCS_MODE_OFF = 8'h08;
  localparam logic [7:0] PCS_SPSRC_OFF = 8'h0C;
  localparam logic [7:0] PCS_SPDIG_OFF = 8'h10;
  localparam logic [7:0] PCS_FBSRC_OFF = 8'h14;
  localparam logic [7:0] PCS_DFACT_OFF = 8'h18;
  localparam logic [7:0] PCS_DSRC_OFF = 8'h1C;
  localparam logic [7:0] PCS_UNITS_OFF = 8'h20;
  localparam logic [7:0] PCS_OUT_OFF = 8'h24;
  localparam logic [7:0] PCS_FB_OFF = 8'h28;
  localparam logic [7:0] PCS_DISP_OFF = 8'h2C;
  // ----------------------------------------------------------------
  // Ranges and reset values (gain, time in tenths; percent in 0.1 %)
  // ----------------------------------------------------------------
  localparam logic [31:0] PCS_KP_MAX = 32'h0000_012C;
  localparam logic [8:0] PCS_KP_RST = 9'h00A;
  localparam logic [31:0] PCS_TI_MAX = 32'h0000_012C;
  localparam logic [8:0] PCS_TI_RST = 9'h00A;
  localparam logic [31:0] PCS_MODE_MAX = 32'h0000_0003;
  localparam logic [31:0] PCS_SPSRC_MAX = 32'h0000_0002;
  localparam logic [31:0] PCS_PCT_MAX = 32'h0000_03E8;
  localparam logic [9:0] PCS_PCT_FULL = 10'h3E8;
  localparam logic [9:0] PCS_SPDIG_RST = 10'h000;
  localparam logic [31:0] PCS_FBSRC_MAX = 32'h0000_0005;
  localparam logic [31:0] PCS_DFACT_MAX = 32'h0000_3E80;
  localparam logic [13:0] PCS_DFACT_RST = 14'h0000;
  localparam logic [31:0] PCS_DSRC_MAX = 32'h0000_0003;
  localparam int PCS_FACT_DIV = 1000;
  localparam int PCS_ACC_SHIFT = 10;
  localparam int PCS_TI_DIV = 1000;
  // ----------------------------------------------------------------
  // Timing: controller update period
  // ----------------------------------------------------------------
  localparam int PCS_CLK_KHZ = 40000;
  localparam int PCS_TICK_US = 1000;
  localparam int PCS_TICK_CYC = (PCS_TICK_US * PCS_CLK_KHZ) / 1000;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] kp;
    logic [8:0] ti;
    logic [1:0] mode;
    logic [1:0] sp_src;
    logic [9:0] sp_dig;
    logic [2:0] fb_src;
  } pcs_pi_cfg_t;
  typedef struct packed {
    logic [13:0] factor;
    logic [1:0] src;
    logic speed_units;
  } pcs_dsp_cfg_t;
  typedef struct packed {
    logic [9:0] ain1;
    logic [9:0] ain2;
    logic [9:0] cur_pct;
    logic [15:0] cur_amps;
    logic [15:0] dc_volts;
    logic [15:0] out_freq;
    logic [15:0] motor_rpm;
    logic [15:0] fieldbus_process_word_two;
  } pcs_meas_t;
endpackage

// [verification/pcs_plant_model.sv]
// Model of the process sensors and motor output stage feeding the measurement bundle
`timescale 1ns/1ps
module pcs_plant_model import pcs_pkg::*; (
  // Clock
  input wire logic clk,
  // Levels chosen by the bench
  input wire pcs_meas_t level,
  // Measurement bundle to the controller
  output pcs_meas_t meas
);
  // Sensors sample once a cycle, so a new level shows one cycle late
  always_ff @(posedge clk) begin
    meas <= level;
  end
endmodule

// [verification/tb.sv]
// Self-checking bench for the process PI controller and display scaling
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0d seen %0d", nm, ex, got); end end
module tb;
  import pcs_pkg::*;
  localparam int TICK = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic standby_wake;
  logic [9:0] freq_ref;
  logic [23:0] display_value;
  pcs_meas_t lvl;
  pcs_meas_t meas;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  integer seed = 85;
  logic [31:0] rv;
  logic [31:0] fct;
  logic [7:0] offs [8] = '{PCS_KP_OFF, PCS_TI_OFF, PCS_MODE_OFF, PCS_SPSRC_OFF,
                           PCS_SPDIG_OFF, PCS_FBSRC_OFF, PCS_DFACT_OFF, PCS_DSRC_OFF};
  logic [31:0] goods [8] = '{PCS_KP_MAX, PCS_TI_MAX, PCS_MODE_MAX, PCS_SPSRC_MAX,
                             PCS_PCT_MAX, PCS_FBSRC_MAX, PCS_DFACT_MAX, PCS_DSRC_MAX};
  // Rows: mode, gain, setpoint source, setpoint, feedback, expected output
  int ct [8][6] = '{'{0, 10, 0, 600, 200, 400}, '{0, 10, 0, 200, 600, 0},
                    '{0, 20, 0, 600, 200, 800}, '{0, 30, 0, 600, 200, 1000},
                    '{1, 10, 0, 200, 600, 400}, '{1, 10, 0, 600, 200, 0},
                    '{0, 10, 1, 700, 300, 400}, '{0, 10, 2, 900, 300, 600}};

  always #12.5 clk = ~clk;

  pcs_plant_model plant (.clk(clk), .level(lvl), .meas(meas));

  pcs_top #(.TICK_CYC(TICK)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .standby_wake(standby_wake),
    .freq_ref(freq_ref), .display_value(display_value));

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Lands past the edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] rnd(input int n);
    return {$random(seed)} % n;
  endfunction

  function automatic logic [31:0] exp_fb(input int s);
    case (s)
      0: return 32'(lvl.ain2);
      1: return 32'(lvl.ain1);
      2: return 32'(lvl.cur_pct);
      3: return (lvl.dc_volts > 16'd1000) ? 32'd1000 : 32'(lvl.dc_volts);
      4: return (lvl.ain1 > lvl.ain2) ? 32'(lvl.ain1 - lvl.ain2) : 32'd0;
      default: return (lvl.ain1 > lvl.ain2) ? 32'(lvl.ain1) : 32'(lvl.ain2);
    endcase
  endfunction

  function automatic logic [23:0] exp_disp(input int s, input int u, input logic [31:0] fb);
    longint v;
    v = (s == 0) ? ((u != 0) ? lvl.motor_rpm : lvl.out_freq) :
        (s == 1) ? lvl.cur_amps : (s == 2) ? lvl.ain2 : fb;
    return 24'((v * fct) / 1000);
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    standby_wake = 1'b0;
    lvl = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(PCS_KP_OFF, rv);
    `CHK("gain reset", 32'(PCS_KP_RST), rv)
    reg_rd(PCS_TI_OFF, rv);
    `CHK("integral reset", 32'(PCS_TI_RST), rv)
    reg_rd(PCS_SPDIG_OFF, rv);
    `CHK("setpoint reset", 32'(PCS_SPDIG_RST), rv)
    reg_rd(PCS_DFACT_OFF, rv);
    `CHK("factor reset", 32'(PCS_DFACT_RST), rv)
    $display("test reset values done");
    // Top of range accepted, one above refused
    for (int i = 0; i < 8; i++) begin
      reg_wr(offs[i], goods[i]);
      reg_wr(offs[i], goods[i] + 32'd1);
      reg_rd(offs[i], rv);
      `CHK("setting kept", goods[i], rv)
    end
    reg_rd(8'h40, rv);
    `CHK("unmapped read", 32'd0, rv)
    $display("test setting ranges done");
    reg_wr(PCS_DSRC_OFF, 32'd3);
    for (int it = 0; it < 10; it++) begin
      @(posedge clk);
      lvl.ain1 <= 10'((it == 0) ? 500 : rnd(1001));
      lvl.ain2 <= 10'((it == 0) ? 500 : rnd(1001));
      lvl.cur_pct <= 10'(rnd(1001));
      lvl.dc_volts <= 16'((it == 1) ? 1000 : rnd(1300));
      fct = (it == 0) ? 32'd16000 : rnd(16001);
      reg_wr(PCS_DFACT_OFF, fct);
      for (int s = 0; s < 6; s++) begin
        reg_wr(PCS_FBSRC_OFF, 32'(s));
        settle(3);
        `CHK("feedback display", exp_disp(3, 0, exp_fb(s)), display_value)
        reg_rd(PCS_FB_OFF, rv);
        `CHK("feedback", exp_fb(s), rv)
      end
    end
    $display("test feedback sources done");
    for (int it = 0; it < 10; it++) begin
      @(posedge clk);
      lvl.out_freq <= 16'(rnd(65536));
      lvl.motor_rpm <= 16'(rnd(65536));
      lvl.cur_amps <= 16'((it == 0) ? 65535 : rnd(65536));
      lvl.ain2 <= 10'(rnd(1001));
      fct = (it == 0) ? 32'd16000 : (it == 1) ? 32'd0 : rnd(16001);
      reg_wr(PCS_DFACT_OFF, fct);
      for (int k = 0; k < 6; k++) begin
        reg_wr(PCS_DSRC_OFF, 32'(k / 2));
        reg_wr(PCS_UNITS_OFF, 32'(k % 2));
        settle(3);
        `CHK("display", exp_disp(k / 2, k % 2, 0), display_value)
      end
    end
    $display("test display scaling done");
    do_reset();
    reg_wr(PCS_TI_OFF, 32'd0);
    for (int r = 0; r < 8; r++) begin
      reg_wr(PCS_MODE_OFF, 32'(ct[r][0]));
      reg_wr(PCS_KP_OFF, 32'(ct[r][1]));
      reg_wr(PCS_SPSRC_OFF, 32'(ct[r][2]));
      reg_wr(PCS_SPDIG_OFF, (ct[r][2] == 0) ? 32'(ct[r][3]) : 32'd0);
      lvl.ain1 <= (ct[r][2] == 1) ? 10'(ct[r][3]) : 10'd0;
      lvl.fieldbus_process_word_two <= (ct[r][2] == 2) ? 16'(ct[r][3]) : 16'd0;
      lvl.ain2 <= 10'(ct[r][4]);
      reg_wr(PCS_FBSRC_OFF, 32'd0);
      settle(3 * TICK);
      `CHK("controller output", 10'(ct[r][5]), freq_ref)
    end
    $display("test controller action done");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      reg_wr(PCS_TI_OFF, 32'd0);
      reg_wr(PCS_MODE_OFF, 32'(m));
      lvl.ain2 <= 10'd0;
      settle(3 * TICK);
      @(posedge clk);
      standby_wake <= 1'b1;
      @(posedge clk);
      standby_wake <= 1'b0;
      #1;
      `CHK("wake output", (m >= 2) ? 10'd1000 : 10'd0, freq_ref)
      settle(3 * TICK);
      `CHK("held after wake", (m >= 2) ? 10'd1000 : 10'd0, freq_ref)
    end
    $display("test standby wake done");
    tally_and_finish();
  end
endmodule
